// ===== design/aesr_evt_latch.sv
// one event engine's flag and detail capture under the shared latching mode
`timescale 1ns/1ps
module aesr_evt_latch
  import aesr_pkg::*;
#(
  parameter int DET_W = 4,
  parameter int HOLD_CYCLES = TEMP_HOLD_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire aesr_lm_t mode,
  input wire logic fire,
  input wire logic [DET_W-1:0] detail_in,
  input wire logic release_latch,
  output logic flag,
  output logic [DET_W-1:0] detail
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] HOLD_LOAD = CW'(HOLD_CYCLES);

  typedef struct packed {
    logic flag;
    logic [DET_W-1:0] detail;
    logic [CW-1:0] cnt;
  } aesr_lat_st_t;

  aesr_lat_st_t st_reg;
  aesr_lat_st_t st_next;

  // flag behaviour follows the latching mode; a fire beats a release
  always_comb begin
    st_next = st_reg;
    if (fire) begin
      st_next.detail = detail_in;
    end
    unique case (mode)
      AESR_LM_NONE: begin
        st_next.flag = fire;
        st_next.cnt = '0;
      end
      AESR_LM_TEMP: begin
        if (fire) begin
          st_next.flag = 1'b1;
          st_next.cnt = HOLD_LOAD;
        end else if (release_latch || st_reg.cnt == CW'(1)) begin
          st_next.flag = 1'b0;
          st_next.cnt = '0;
        end else if (st_reg.cnt != '0) begin
          st_next.cnt = st_reg.cnt - CW'(1);
        end else begin
          st_next.flag = 1'b0;
        end
      end
      AESR_LM_PERM: begin
        st_next.cnt = '0;
        if (fire) begin
          st_next.flag = 1'b1;
        end else if (release_latch) begin
          st_next.flag = 1'b0;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flag = st_reg.flag;
  assign detail = st_reg.detail;

endmodule : aesr_evt_latch

// ===== design/aesr_orient_hold.sv
// orientation code holder, frozen while blocked, blind to latching
`timescale 1ns/1ps
module aesr_orient_hold
  import aesr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] orient_in,
  input wire logic orient_block,
  output logic [2:0] orient,
  output logic changed
);

  typedef struct packed {
    logic [2:0] orient;
    logic changed;
  } aesr_ori_st_t;

  aesr_ori_st_t st_reg;
  aesr_ori_st_t st_next;

  // track the live code unless a blocking condition holds it
  always_comb begin
    st_next = st_reg;
    st_next.changed = 1'b0;
    if (!orient_block) begin
      st_next.orient = orient_in;
      st_next.changed = (orient_in != st_reg.orient);
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign orient = st_reg.orient;
  assign changed = st_reg.changed;

endmodule : aesr_orient_hold

// ===== design/aesr_pkg.sv
// package of constants, types and helpers for the accelerometer event status register bank
// ****************************************************************
// ****************************************************************
package aesr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MOTION = 8'h0B;
  localparam logic [7:0] IDX_POSE = 8'h0C;
  localparam logic [7:0] IDX_RSVD = 8'h0D;
  localparam logic [7:0] IDX_FILL = 8'h0E;
  localparam logic [7:0] IDX_LATCH = 8'h10;
  localparam logic [7:0] IDX_FUNC = 8'h11;
  localparam logic [7:0] IDX_FCFG = 8'h12;
  localparam logic [7:0] IDX_ISTAT = 8'h13;
  localparam logic [7:0] IDX_ICLR = 8'h14;
  localparam logic [7:0] IDX_IEN = 8'h15;

  // field positions
  localparam int TAP_LSB = 4;
  localparam int SLOPE_LSB = 0;
  localparam int HIGH_LSB = 0;
  localparam int FLAT_BIT = 7;
  localparam int ORIENT_LSB = 4;
  localparam int OVR_BIT = 7;
  localparam int RELEASE_BIT = 7;
  localparam int LFLAG_LSB = 4; // engine flag levels in the latch register read

  // interrupt status, clear and enable layout
  localparam int ST_TAP = 0;
  localparam int ST_SLOPE = 1;
  localparam int ST_HIGH = 2;
  localparam int ST_FLAT = 3;
  localparam int ST_ORIENT = 4;
  localparam int ST_OVR = 5;
  localparam int ST_W = 6;

  // function enable layout
  localparam int FE_TAP = 0;
  localparam int FE_SLOPE = 1;
  localparam int FE_HIGH = 2;
  localparam int FE_FLAT = 3;
  localparam int FE_ORIENT = 4;
  localparam int FE_W = 5;

  // values after reset, and the latch codes for no and permanent latching
  localparam logic [3:0] LATCH_RST = 4'h0;
  localparam logic [FE_W-1:0] FUNC_RST = 5'h00;
  localparam logic [ST_W-1:0] IEN_RST = 6'h00;
  localparam logic [7:0] FCFG_RST = 8'h00;
  localparam logic [3:0] LATCH_NONE = 4'h0;
  localparam logic [2:0] LATCH_PERM_LOW = 3'h7;

  // cycles a temporarily latched flag stays up
  localparam int TEMP_HOLD_CYCLES = 1000;

  typedef enum logic [1:0] {AESR_LM_NONE, AESR_LM_TEMP, AESR_LM_PERM} aesr_lm_t;

  // latch code to latching mode
  function automatic aesr_lm_t aesr_lm_decode(input logic [3:0] code);
    aesr_lm_t m;
    m = AESR_LM_TEMP;
    if (code == LATCH_NONE) begin
      m = AESR_LM_NONE;
    end else if (code[2:0] == LATCH_PERM_LOW) begin
      m = AESR_LM_PERM;
    end
    return m;
  endfunction : aesr_lm_decode

endpackage : aesr_pkg

// ===== design/aesr_top.sv
// accelerometer event status register bank with ahb-lite slave and interrupt
`timescale 1ns/1ps
module aesr_top
  import aesr_pkg::*;
#(
  parameter int FIFO_DEPTH = 32,
  parameter int HOLD_CYCLES = TEMP_HOLD_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic tap_fire,
  input wire logic tap_sign,
  input wire logic [2:0] tap_axis,
  input wire logic slope_fire,
  input wire logic slope_sign,
  input wire logic [2:0] slope_axis,
  input wire logic high_fire,
  input wire logic high_sign,
  input wire logic [2:0] high_axis,
  input wire logic flat_state,
  input wire logic [2:0] orient_in,
  input wire logic orient_block,
  input wire logic fifo_push,
  input wire logic fifo_pop,
  output logic [FE_W-1:0] func_en,
  output logic fifo_cfg_wr,
  output logic irq
);

  // ****************************************************************
  // state
  // ****************************************************************

  typedef struct packed {
    // bus pipeline and read snapshot
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_idx;
    logic [31:0] rdata;
    // control registers
    logic [3:0] latch_code;
    logic release_p;
    logic [FE_W-1:0] func_en;
    logic [7:0] fcfg;
    logic cfg_wr_p;
    // fifo status
    logic ovr;
    logic [6:0] fcnt;
    // event and interrupt state
    logic flat;
    logic [ST_W-1:0] istat;
    logic [ST_W-1:0] ien;
    logic irq;
  } aesr_top_st_t;

  aesr_top_st_t st_reg;
  aesr_top_st_t st_next;

  localparam logic [6:0] FIFO_FULL = 7'(FIFO_DEPTH);

  // ****************************************************************
  // event engines and orientation
  // ****************************************************************

  logic tap_flag;
  logic slope_flag;
  logic high_flag;
  logic [3:0] tap_det;
  logic [3:0] slope_det;
  logic [3:0] high_det;
  logic [2:0] orient;
  logic orient_chg;
  aesr_lm_t lmode;
  logic tap_go;
  logic slope_go;
  logic high_go;
  logic [2:0] eng_flags;

  // fires count only for enabled functions
  assign lmode = aesr_lm_decode(st_reg.latch_code);
  assign tap_go = tap_fire & st_reg.func_en[FE_TAP];
  assign slope_go = slope_fire & st_reg.func_en[FE_SLOPE];
  assign high_go = high_fire & st_reg.func_en[FE_HIGH];

  // tap sign and cause axes
  aesr_evt_latch #(
    .DET_W(4),
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_tap (
    .hclk(hclk),
    .hresetn(hresetn),
    .mode(lmode),
    .fire(tap_go),
    .detail_in({tap_sign, tap_axis}),
    .release_latch(st_reg.release_p),
    .flag(tap_flag),
    .detail(tap_det)
  );

  // slope sign and cause axes
  aesr_evt_latch #(
    .DET_W(4),
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_slope (
    .hclk(hclk),
    .hresetn(hresetn),
    .mode(lmode),
    .fire(slope_go),
    .detail_in({slope_sign, slope_axis}),
    .release_latch(st_reg.release_p),
    .flag(slope_flag),
    .detail(slope_det)
  );

  // high-g sign and cause axes
  aesr_evt_latch #(
    .DET_W(4),
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_high (
    .hclk(hclk),
    .hresetn(hresetn),
    .mode(lmode),
    .fire(high_go),
    .detail_in({high_sign, high_axis}),
    .release_latch(st_reg.release_p),
    .flag(high_flag),
    .detail(high_det)
  );

  // orientation follows the live code unless blocked, regardless of latching
  aesr_orient_hold u_orient (
    .hclk(hclk),
    .hresetn(hresetn),
    .orient_in(orient_in),
    .orient_block(orient_block),
    .orient(orient),
    .changed(orient_chg)
  );

  // engine flag levels under the latching mode, shown beside the latch code
  assign eng_flags = {high_flag, slope_flag, tap_flag};

  // ****************************************************************
  // helpers
  // ****************************************************************

  // register index carried by a byte address; the upper bits alias
  function automatic logic [7:0] bus_idx(input logic [31:0] a);
    return a[9:2];
  endfunction : bus_idx

  // a push into a full queue with no pop in the same cycle
  function automatic logic ovr_hit(input logic push, input logic pop, input logic [6:0] cnt);
    return push & ~pop & (cnt == FIFO_FULL);
  endfunction : ovr_hit

  // next fill level: a config write empties, a lone push below full or a lone pop above empty moves it by one
  function automatic logic [6:0] fill_step(
    input logic clr,
    input logic push,
    input logic pop,
    input logic [6:0] cnt
  );
    logic [6:0] n;
    n = cnt;
    if (clr) begin
      n = 7'h00;
    end else if (push && !pop && cnt != FIFO_FULL) begin
      n = cnt + 7'h01;
    end else if (pop && !push && cnt != 7'h00) begin
      n = cnt - 7'h01;
    end
    return n;
  endfunction : fill_step

  // one cause bit per interrupt source, each but overrun gated by its function enable
  function automatic logic [ST_W-1:0] ev_vector(input aesr_top_st_t s, input logic ovr_in);
    logic [ST_W-1:0] v;
    v = '0;
    v[ST_TAP] = tap_go;
    v[ST_SLOPE] = slope_go;
    v[ST_HIGH] = high_go;
    v[ST_FLAT] = (flat_state != s.flat) & s.func_en[FE_FLAT];
    v[ST_ORIENT] = orient_chg & s.func_en[FE_ORIENT];
    v[ST_OVR] = ovr_in;
    return v;
  endfunction : ev_vector

  // sticky update; a cause in the same cycle as its clear keeps the bit set
  function automatic logic [ST_W-1:0] sticky(
    input logic [ST_W-1:0] cur,
    input logic [ST_W-1:0] clr,
    input logic [ST_W-1:0] hit
  );
    return (cur & ~clr) | hit;
  endfunction : sticky

  // level interrupt while any enabled status bit is set
  function automatic logic irq_level(input logic [ST_W-1:0] stat, input logic [ST_W-1:0] en);
    return |(stat & en);
  endfunction : irq_level

  // ****************************************************************
  // read decode
  // ****************************************************************

  // register contents by index; unmapped and reserved read zero
  function automatic logic [31:0] rd_mux(input logic [7:0] idx, input aesr_top_st_t s);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (idx)
      IDX_MOTION: begin
        d[TAP_LSB +: 4] = tap_det;
        d[SLOPE_LSB +: 4] = slope_det;
      end
      IDX_POSE: begin
        d[FLAT_BIT] = s.flat;
        d[ORIENT_LSB +: 3] = orient;
        d[HIGH_LSB +: 4] = high_det;
      end
      IDX_RSVD: d = 32'h0000_0000;
      IDX_FILL: begin
        d[OVR_BIT] = s.ovr;
        d[6:0] = s.fcnt;
      end
      IDX_LATCH: begin
        d[3:0] = s.latch_code;
        d[LFLAG_LSB +: 3] = eng_flags;
      end
      IDX_FUNC: d[FE_W-1:0] = s.func_en;
      IDX_FCFG: d[7:0] = s.fcfg;
      IDX_ISTAT: d[ST_W-1:0] = s.istat;
      IDX_IEN: d[ST_W-1:0] = s.ien;
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : rd_mux

  // ****************************************************************
  // next state
  // ****************************************************************

  logic take;
  logic wr_now;
  logic cfg_hit;
  logic ovr_now;
  logic [ST_W-1:0] ev_set;
  logic [ST_W-1:0] clr_mask;

  // address phase accepted on a nonseq or seq with hready high
  assign take = hsel & htrans[1] & hready;
  assign wr_now = st_reg.ap_valid & st_reg.ap_write;

  // fifo config write in its data phase, and a push that finds the queue full
  assign cfg_hit = wr_now & (st_reg.ap_idx == IDX_FCFG);
  assign ovr_now = ovr_hit(fifo_push, fifo_pop, st_reg.fcnt);

  always_comb begin
    st_next = st_reg;
    st_next.release_p = 1'b0;
    st_next.cfg_wr_p = 1'b0;
    clr_mask = '0;
    // bus address phase; reads are sampled here and change nothing
    st_next.ap_valid = take;
    if (take) begin
      st_next.ap_write = hwrite;
      st_next.ap_idx = bus_idx(haddr);
      if (!hwrite) begin
        st_next.rdata = rd_mux(bus_idx(haddr), st_reg);
      end
    end
    // bus data phase writes
    if (wr_now) begin
      unique case (st_reg.ap_idx)
        IDX_LATCH: begin
          st_next.latch_code = hwdata[3:0];
          st_next.release_p = hwdata[RELEASE_BIT];
        end
        IDX_FUNC: st_next.func_en = hwdata[FE_W-1:0];
        IDX_FCFG: begin
          st_next.fcfg = hwdata[7:0];
          st_next.cfg_wr_p = 1'b1;
        end
        IDX_ICLR: clr_mask = hwdata[ST_W-1:0];
        IDX_IEN: st_next.ien = hwdata[ST_W-1:0];
        default: st_next.fcfg = st_reg.fcfg;
      endcase
    end
    // flat state shown as sampled from the engine
    st_next.flat = flat_state;
    // fill level counter; config write clears, drain returns to zero naturally
    st_next.fcnt = fill_step(cfg_hit, fifo_push, fifo_pop, st_reg.fcnt);
    if (cfg_hit) begin
      st_next.ovr = 1'b0;
    end
    // overrun: push into a full queue, set beats the config clear
    if (ovr_now) begin
      st_next.ovr = 1'b1;
    end
    // sticky interrupt status; set wins over clear
    ev_set = ev_vector(st_reg, ovr_now);
    st_next.istat = sticky(st_reg.istat, clr_mask, ev_set);
    st_next.irq = irq_level(st_next.istat, st_next.ien);
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
      st_reg.latch_code <= LATCH_RST;
      st_reg.func_en <= FUNC_RST;
      st_reg.fcfg <= FCFG_RST;
      st_reg.ien <= IEN_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_reg.rdata;
  assign func_en = st_reg.func_en;
  assign fifo_cfg_wr = st_reg.cfg_wr_p;
  assign irq = st_reg.irq;

  // transfer size is not decoded; only whole words are served
  logic unused_hsize;
  assign unused_hsize = ^hsize;

endmodule : aesr_top

// ===== verif/aesr_host_model.sv
// host controller model driving single ahb-lite word transfers
`timescale 1ns/1ps
module aesr_host_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one transfer; entered just after a rising edge, ends at the data phase edge
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    hwdata <= ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : xfer
endmodule : aesr_host_model

// ===== verif/aesr_top_sva.sv
// checker for the accelerometer event status register bank ports
`timescale 1ns/1ps
module aesr_top_sva
  import aesr_pkg::*;
#(
  parameter int FIFO_DEPTH = 32,
  parameter int HOLD_CYCLES = TEMP_HOLD_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic tap_fire,
  input wire logic slope_fire,
  input wire logic high_fire,
  input wire logic flat_state,
  input wire logic [2:0] orient_in,
  input wire logic orient_block,
  input wire logic fifo_push,
  input wire logic [FE_W-1:0] func_en,
  input wire logic fifo_cfg_wr,
  input wire logic irq
);
  wire tk = hsel & htrans[1] & hready;
  wire tkw = tk & hwrite;
  wire wr_cfg = tkw & (haddr[9:2] == IDX_FCFG);
  wire wr_fen = tkw & (haddr[9:2] == IDX_FUNC);
  logic flat_q;
  logic blk_q;
  logic [2:0] orient_q;
  logic [3:0] since_ev;
  logic [3:0] since_wr;
  // a released orientation block may pass a code that changed long ago
  wire ev_in = tap_fire | slope_fire | high_fire | fifo_push | tkw | (blk_q & ~orient_block);
  wire ev = ev_in | (flat_state != flat_q) | (orient_in != orient_q);
  // cycles since the last possible interrupt cause and since the last write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flat_q <= 1'b0;
      blk_q <= 1'b0;
      orient_q <= 3'h0;
      since_ev <= 4'hF;
      since_wr <= 4'hF;
    end else begin
      flat_q <= flat_state;
      blk_q <= orient_block;
      orient_q <= orient_in;
      since_ev <= ev ? 4'h0 : (since_ev == 4'hF ? 4'hF : since_ev + 4'h1);
      since_wr <= tkw ? 4'h0 : (since_wr == 4'hF ? 4'hF : since_wr + 4'h1);
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_cfg_pulse; wr_cfg |-> ##2 fifo_cfg_wr; endproperty
  a_cfg_pulse: assert property (p_cfg_pulse) else $error("config pulse missing");
  property p_cfg_only; fifo_cfg_wr |-> $past(wr_cfg, 2); endproperty
  a_cfg_only: assert property (p_cfg_only) else $error("config pulse without write");
  property p_cfg_one; fifo_cfg_wr |=> !fifo_cfg_wr; endproperty
  a_cfg_one: assert property (p_cfg_one) else $error("config pulse too long");
  property p_en_src; $changed(func_en) |-> $past(wr_fen, 2); endproperty
  a_en_src: assert property (p_en_src) else $error("enable changed without write");
  property p_irq_src; $rose(irq) |-> since_ev < 4'h6; endproperty
  a_irq_src: assert property (p_irq_src) else $error("interrupt without event");
  property p_irq_fall; $fell(irq) |-> since_wr < 4'h6; endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without write");
  property p_ok; hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("bad bus response");
  property p_rd_hold; !$past(tk & !hwrite) |-> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  c_tap: cover property (tap_fire && func_en[FE_TAP]);
  c_irq: cover property ($rose(irq));
  c_cfg: cover property (fifo_cfg_wr);
endmodule : aesr_top_sva
bind aesr_top aesr_top_sva #(.FIFO_DEPTH(FIFO_DEPTH), .HOLD_CYCLES(HOLD_CYCLES)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .tap_fire(tap_fire), .slope_fire(slope_fire), .high_fire(high_fire), .flat_state(flat_state),
  .orient_in(orient_in), .orient_block(orient_block), .fifo_push(fifo_push), .func_en(func_en),
  .fifo_cfg_wr(fifo_cfg_wr), .irq(irq)
);

// ===== verif/tb.sv
// self-checking testbench for the event status register bank
`timescale 1ns/1ps
module tb
  import aesr_pkg::*;
;
  localparam int DEPTH = 8;
  localparam int HOLD = 8;
  logic hclk, hresetn, hready, hsel, hwrite, hreadyout, hresp, irq, fifo_cfg_wr;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize, tap_axis, slope_axis, high_axis, orient_in;
  logic tap_fire, tap_sign, slope_fire, slope_sign, high_fire, high_sign;
  logic flat_state, orient_block, fifo_push, fifo_pop;
  logic [FE_W-1:0] func_en;
  int bad_count, n_checks;
  assign hready = hreadyout;
  // free running clock
  always #2 hclk = ~hclk;
  aesr_top #(.FIFO_DEPTH(DEPTH), .HOLD_CYCLES(HOLD)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .tap_fire(tap_fire), .tap_sign(tap_sign), .tap_axis(tap_axis),
    .slope_fire(slope_fire), .slope_sign(slope_sign), .slope_axis(slope_axis),
    .high_fire(high_fire), .high_sign(high_sign), .high_axis(high_axis), .flat_state(flat_state),
    .orient_in(orient_in), .orient_block(orient_block), .fifo_push(fifo_push), .fifo_pop(fifo_pop),
    .func_en(func_en), .fifo_cfg_wr(fifo_cfg_wr), .irq(irq)
  );
  aesr_host_model host (
    .hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    host.xfer(1'b1, idx, d, rv);
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    host.xfer(1'b0, idx, 32'h0, rv);
  endtask : rd
  task automatic fifo(input int n, input logic psh);
    fifo_push <= psh;
    fifo_pop <= !psh;
    tick(n);
    fifo_push <= 1'b0;
    fifo_pop <= 1'b0;
  endtask : fifo
  task automatic end_sim;
    $display("mismatches %0d, checks %0d", bad_count, n_checks);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(IDX_ISTAT); chk(rv, 32'h0);
    wr(IDX_RSVD, 32'hFF);
    rd(IDX_RSVD); chk(rv, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask : t_reset
  task automatic t_motion;
    wr(IDX_FUNC, 32'h1F);
    for (int i = 0; i < 3; i++) begin
      tap_fire <= 1'b1;
      slope_fire <= 1'b1;
      tap_sign <= i[0];
      slope_sign <= !i[0];
      tap_axis <= 3'h1 << i;
      slope_axis <= 3'h4 >> i;
      tick(1);
      tap_fire <= 1'b0;
      slope_fire <= 1'b0;
      rd(IDX_MOTION); chk(rv, {24'h0, i[0], 3'h1 << i, !i[0], 3'h4 >> i});
    end
    wr(IDX_FUNC, 32'h1C);
    tick(1);
    chk({27'h0, func_en}, 32'h1C);
    tap_fire <= 1'b1;
    slope_fire <= 1'b1;
    tap_axis <= 3'h7;
    tick(1);
    tap_fire <= 1'b0;
    slope_fire <= 1'b0;
    rd(IDX_MOTION); chk(rv, 32'h49);
    wr(IDX_FUNC, 32'h1F);
  endtask : t_motion
  task automatic t_pose;
    high_fire <= 1'b1;
    high_sign <= 1'b1;
    high_axis <= 3'h2;
    flat_state <= 1'b1;
    tick(1);
    high_fire <= 1'b0;
    tick(1);
    rd(IDX_POSE); chk(rv, 32'h8A);
    wr(IDX_LATCH, 32'h7);
    for (int c = 0; c < 8; c++) begin
      orient_in <= c[2:0];
      tick(2);
      rd(IDX_POSE); chk(rv, {24'h0, 1'b1, c[2:0], 4'hA});
    end
    orient_block <= 1'b1;
    orient_in <= 3'h2;
    tick(2);
    rd(IDX_POSE); chk(rv, 32'hFA);
    orient_block <= 1'b0;
    tick(2);
    rd(IDX_POSE); chk(rv, 32'hAA);
  endtask : t_pose
  // engine flag levels in the latch register under each latching mode
  task automatic t_latch;
    wr(IDX_LATCH, 32'h87);
    tap_fire <= 1'b1;
    tick(1);
    tap_fire <= 1'b0;
    tick(20);
    rd(IDX_LATCH); chk(rv, 32'h17);
    wr(IDX_LATCH, 32'h87);
    tick(1);
    rd(IDX_LATCH); chk(rv, 32'h07);
    wr(IDX_LATCH, 32'h01);
    tap_fire <= 1'b1;
    tick(1);
    tap_fire <= 1'b0;
    rd(IDX_LATCH); chk(rv, 32'h11);
    tick(HOLD - 4);
    rd(IDX_LATCH); chk(rv, 32'h11);
    rd(IDX_LATCH); chk(rv, 32'h01);
    wr(IDX_LATCH, 32'h00);
    tap_fire <= 1'b1;
    tick(1);
    tap_fire <= 1'b0;
    rd(IDX_LATCH); chk(rv, 32'h10);
    rd(IDX_LATCH); chk(rv, 32'h00);
  endtask : t_latch
  task automatic t_fifo;
    fifo(DEPTH, 1'b1);
    rd(IDX_FILL); chk(rv, DEPTH);
    fifo(1, 1'b1);
    rd(IDX_FILL); chk(rv, 32'h80 | DEPTH);
    rd(IDX_FILL); chk(rv, 32'h80 | DEPTH);
    rd(IDX_ISTAT); chk(rv, 32'h3F);
    fifo(3, 1'b0);
    rd(IDX_FILL); chk(rv, 32'h80 | (DEPTH - 3));
    wr(IDX_FCFG, 32'h0);
    rd(IDX_FILL); chk(rv, 32'h0);
    fifo(2, 1'b1);
    fifo(2, 1'b0);
    rd(IDX_FILL); chk(rv, 32'h0);
  endtask : t_fifo
  task automatic t_irq;
    wr(IDX_ICLR, 32'h3F);
    wr(IDX_IEN, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    tap_fire <= 1'b1;
    tick(1);
    tap_fire <= 1'b0;
    tick(2);
    chk({31'h0, irq}, 32'h1);
    rd(IDX_ISTAT); chk(rv, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_ICLR, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IEN, 32'h0);
    tap_fire <= 1'b1;
    tick(1);
    tap_fire <= 1'b0;
    tick(2);
    chk({31'h0, irq}, 32'h0);
    rd(IDX_ISTAT); chk(rv, 32'h1);
  endtask : t_irq
  // main sequence
  initial begin
    {hclk, hresetn, tap_fire, tap_sign, slope_fire, slope_sign, high_fire, high_sign} = 8'h00;
    {flat_state, orient_block, fifo_push, fifo_pop} = 4'h0;
    {tap_axis, slope_axis, high_axis, orient_in} = 12'h000;
    bad_count = 0;
    n_checks = 0;
    tick(8);
    hresetn <= 1'b1;
    t_reset;
    t_motion;
    t_pose;
    t_latch;
    t_fifo;
    t_irq;
    end_sim;
  end
  // watchdog against a hung transfer
  initial begin
    tick(20000);
    bad_count++;
    end_sim;
  end
endmodule : tb
